/* File: pkg/mpc_cfg_if.sv */
// Carrier between the register front end and the pin-function bank.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface mpc_cfg_if;
   import mpc_pkg::*;
   logic wr_en;
   mpc_cfg_sel_t sel;
   logic [7:0] wdata;
   logic lock;
   logic [7:0] q [MPC_NUM_CFG];

   modport bank (input wr_en, input sel, input wdata, input lock, output q);
   modport ctrl (output wr_en, output sel, output wdata, output lock, input q);
endinterface

`default_nettype wire

/* File: pkg/mpc_pkg.sv */
// Types shared by the misc pin control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mpc_pkg;

   // ----------------------------------------
   // Bus slave states, one-hot
   // ----------------------------------------
   typedef enum logic [2:0] {
      MPC_S_IDLE = 3'b001,
      MPC_S_WR = 3'b010,
      MPC_S_RD = 3'b100
   } mpc_state_t;

   typedef logic [1:0] mpc_cfg_sel_t;

   localparam int MPC_NUM_CFG = 3;

endpackage

`default_nettype wire

/* File: pkg/mpc_regs.svh */
// Register offsets, field positions, reset values for the misc pin control block.
// Assumes a 32-bit AHB-Lite word map; only haddr[7:0] is decoded.
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MPC_OFF_MISC_CTRL 8'h00
`define MPC_OFF_PIN_CFG_A 8'h04
`define MPC_OFF_PIN_CFG_B 8'h08
`define MPC_OFF_PIN_CFG_C 8'h0c
`define MPC_OFF_RSV_A 8'h10
`define MPC_OFF_RSV_B 8'h14
`define MPC_OFF_RSV_C 8'h18
`define MPC_OFF_RSV_D 8'h1c
`define MPC_OFF_RSV_E 8'h20
`define MPC_OFF_RSV_F 8'h24
`define MPC_OFF_STATUS 8'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MPC_BIT_DRIVE 0
`define MPC_BIT_LOCK 1
`define MPC_BIT_PULL_DIS 2
`define MPC_BIT_FUNC 0
`define MPC_BIT_ST_WAKE 0
`define MPC_BIT_ST_MODE 1
`define MPC_BIT_ST_PIN 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPC_RST_PULL_DIS 1'b0
`define MPC_RST_LOCK 1'b0
`define MPC_RST_DRIVE 1'b0
`define MPC_RST_PIN_CFG 8'h00

`endif

/* File: src/mpc_cfg_bank.sv */
// Three pin-function configuration registers with a write lock.
// Assumes the controller raises wr_en for one cycle per bus write.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_regs.svh"

module mpc_cfg_bank
   import mpc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   mpc_cfg_if.bank cfg
);
   genvar g;
   generate
      for (g = 0; g < MPC_NUM_CFG; g++) begin : g_cfg
         logic [7:0] r;
         logic [7:0] next_r;

         always_comb begin
            next_r = r;
            if (cfg.wr_en && cfg.sel == mpc_cfg_sel_t'(g) && !cfg.lock) begin
               next_r = cfg.wdata;
            end
         end

         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               r <= `MPC_RST_PIN_CFG;
            end else begin
               r <= next_r;
            end
         end

         assign cfg.q[g] = r;
      end
   endgenerate
endmodule

`default_nettype wire

/* File: src/mpc_misc_pin_ctrl.sv */
// Misc pin control: pull gating, pin-function write lock, status-change pin.
// Assumes a single AHB-Lite master, word transfers only, and a wake flag
// from card configuration logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_regs.svh"

module mpc_misc_pin_ctrl
   import mpc_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   // AHB-Lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // Card side
   input wire logic CARD_WAKE_I,
   input wire logic PCCARD_MODE_I,
   input wire logic STATUS_CHANGE_PIN_I,
   output logic STATUS_CHANGE_PIN_O,
   output logic STATUS_CHANGE_PIN_OE_N_O,
   output logic PIN_PULL_EN_O,
   output logic [7:0] PIN_CFG_A_O,
   output logic [7:0] PIN_CFG_B_O,
   output logic [7:0] PIN_CFG_C_O
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   mpc_state_t state;
   mpc_state_t next_state;
   logic [7:0] addr_q;
   logic [7:0] next_addr_q;
   logic [31:0] hrdata;
   logic [31:0] next_hrdata;
   logic hreadyout;
   logic next_hreadyout;
   logic hresp;
   logic next_hresp;
   logic accept;
   logic wr_phase;
   logic [31:0] rd_mux;

   logic pin_pull_disable;
   logic next_pin_pull_disable;
   logic pin_cfg_write_lock;
   logic next_pin_cfg_write_lock;
   logic status_change_drive;
   logic next_status_change_drive;
   logic pin_out;
   logic next_pin_out;
   logic pin_oe_n;
   logic next_pin_oe_n;
   logic pull_en;
   logic next_pull_en;
   logic [7:0] cfg_a;
   logic [7:0] cfg_b;
   logic [7:0] cfg_c;
   logic [7:0] next_cfg_a;
   logic [7:0] next_cfg_b;
   logic [7:0] next_cfg_c;

   logic misc_wr;
   logic status_change_pin_func;
   logic [1:0] sync_in;
   logic [1:0] sync_out;
   logic pccard_mode;
   logic status_change_pin;

   mpc_cfg_if cfg_bus ();

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Mode strap and pin level both come from outside the clock domain
   assign sync_in = {PCCARD_MODE_I, STATUS_CHANGE_PIN_I};

   mpc_sync #(
      .W(2)
   ) u_sync (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .d_i(sync_in),
      .q_o(sync_out)
   );

   assign pccard_mode = sync_out[1];
   assign status_change_pin = sync_out[0];
   // The drive bit reads back through these stages, so a read right
   // after a write can still show the old pin level.

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   // Reads take one wait state so that a write in its data phase has
   // already landed before the read mux is sampled.
   // HSIZE is not decoded: every register is one aligned word, so a
   // narrower transfer acts on the whole word.
   assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
   assign wr_phase = (state == MPC_S_WR);

   always_comb begin
      next_state = state;
      next_addr_q = addr_q;
      next_hrdata = hrdata;
      next_hreadyout = hreadyout;
      next_hresp = 1'b0;
      case (state)
         MPC_S_RD: begin
            next_hrdata = rd_mux;
            next_hreadyout = 1'b1;
            next_state = MPC_S_IDLE;
         end
         MPC_S_WR: begin
            next_hreadyout = 1'b1;
            next_state = MPC_S_IDLE;
            if (accept) begin
               next_addr_q = HADDR_I[7:0];
               if (HWRITE_I) begin
                  next_state = MPC_S_WR;
               end else begin
                  next_state = MPC_S_RD;
                  next_hreadyout = 1'b0;
               end
            end
         end
         MPC_S_IDLE: begin
            next_hreadyout = 1'b1;
            if (accept) begin
               next_addr_q = HADDR_I[7:0];
               if (HWRITE_I) begin
                  next_state = MPC_S_WR;
               end else begin
                  next_state = MPC_S_RD;
                  next_hreadyout = 1'b0;
               end
            end
         end
         // A corrupted state code falls back to idle with the bus ready
         default: begin
            next_state = MPC_S_IDLE;
            next_hreadyout = 1'b1;
         end
      endcase
   end

   // ----------------------------------------
   // Bus state register
   // ----------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         state <= MPC_S_IDLE;
         addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         state <= next_state;
         addr_q <= next_addr_q;
         hrdata <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp <= next_hresp;
      end
   end

   // ----------------------------------------
   // Bus outputs
   // ----------------------------------------
   assign HRDATA_O = hrdata;
   assign HREADYOUT_O = hreadyout;
   assign HRESP_O = hresp;

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Reserved and unmapped words read as zero; writes to them are dropped
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_q == `MPC_OFF_MISC_CTRL) begin
         rd_mux[`MPC_BIT_PULL_DIS] = pin_pull_disable;
         rd_mux[`MPC_BIT_LOCK] = pin_cfg_write_lock;
         rd_mux[`MPC_BIT_DRIVE] = ~status_change_pin;
      end else if (addr_q == `MPC_OFF_PIN_CFG_A) begin
         rd_mux[7:0] = cfg_bus.q[0];
      end else if (addr_q == `MPC_OFF_PIN_CFG_B) begin
         rd_mux[7:0] = cfg_bus.q[1];
      end else if (addr_q == `MPC_OFF_PIN_CFG_C) begin
         rd_mux[7:0] = cfg_bus.q[2];
      // Status word is read-only and carries the raw wake flag plus the synced mode and pin levels
      end else if (addr_q == `MPC_OFF_STATUS) begin
         rd_mux[`MPC_BIT_ST_WAKE] = CARD_WAKE_I;
         rd_mux[`MPC_BIT_ST_MODE] = pccard_mode;
         rd_mux[`MPC_BIT_ST_PIN] = status_change_pin;
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Pin-function bank
   // ----------------------------------------
   // Write strobe lands at the end of the data phase, when HWDATA stands
   always_comb begin
      cfg_bus.wr_en = 1'b0;
      cfg_bus.sel = 2'h0;
      if (wr_phase) begin
         if (addr_q == `MPC_OFF_PIN_CFG_A) begin
            cfg_bus.wr_en = 1'b1;
            cfg_bus.sel = 2'h0;
         end else if (addr_q == `MPC_OFF_PIN_CFG_B) begin
            cfg_bus.wr_en = 1'b1;
            cfg_bus.sel = 2'h1;
         end else if (addr_q == `MPC_OFF_PIN_CFG_C) begin
            cfg_bus.wr_en = 1'b1;
            cfg_bus.sel = 2'h2;
         end
      end
   end

   assign cfg_bus.wdata = HWDATA_I[7:0];
   // The lock covers the three pin-function words only, never itself
   assign cfg_bus.lock = pin_cfg_write_lock;

   mpc_cfg_bank u_bank (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .cfg(cfg_bus)
   );

   assign status_change_pin_func = cfg_bus.q[2][`MPC_BIT_FUNC];

   // ----------------------------------------
   // Misc control bits
   // ----------------------------------------
   assign misc_wr = wr_phase && (addr_q == `MPC_OFF_MISC_CTRL);

   always_comb begin
      next_pin_pull_disable = pin_pull_disable;
      next_pin_cfg_write_lock = pin_cfg_write_lock;
      next_status_change_drive = status_change_drive;
      // The lock bit itself is always writable so software can undo it
      if (misc_wr) begin
         next_pin_pull_disable = HWDATA_I[`MPC_BIT_PULL_DIS];
         next_pin_cfg_write_lock = HWDATA_I[`MPC_BIT_LOCK];
      end
      // ISA mode leaves the bit frozen: the pin belongs to another function
      if (!pccard_mode) begin
         next_status_change_drive = status_change_drive;
      end else if (status_change_pin_func) begin
         // A low wake flag is a level clear and beats a write of 1
         if (!CARD_WAKE_I) begin
            next_status_change_drive = 1'b0;
         end else if (misc_wr && HWDATA_I[`MPC_BIT_DRIVE]) begin
            next_status_change_drive = 1'b1;
         end
      end else if (misc_wr) begin
         next_status_change_drive = HWDATA_I[`MPC_BIT_DRIVE];
      end
   end

   // ----------------------------------------
   // Misc control registers
   // ----------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         pin_pull_disable <= `MPC_RST_PULL_DIS;
         pin_cfg_write_lock <= `MPC_RST_LOCK;
         status_change_drive <= `MPC_RST_DRIVE;
      end else begin
         pin_pull_disable <= next_pin_pull_disable;
         pin_cfg_write_lock <= next_pin_cfg_write_lock;
         status_change_drive <= next_status_change_drive;
      end
   end

   // ----------------------------------------
   // Pin outputs
   // ----------------------------------------
   // One cycle of latency keeps every output on a flop
   always_comb begin
      next_pull_en = ~pin_pull_disable;
      next_pin_out = ~status_change_drive;
      next_pin_oe_n = ~pccard_mode;
      next_cfg_a = cfg_bus.q[0];
      next_cfg_b = cfg_bus.q[1];
      next_cfg_c = cfg_bus.q[2];
   end

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         pull_en <= 1'b1;
         pin_out <= 1'b1;
         pin_oe_n <= 1'b1;
         cfg_a <= `MPC_RST_PIN_CFG;
         cfg_b <= `MPC_RST_PIN_CFG;
         cfg_c <= `MPC_RST_PIN_CFG;
      end else begin
         pull_en <= next_pull_en;
         pin_out <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
         cfg_a <= next_cfg_a;
         cfg_b <= next_cfg_b;
         cfg_c <= next_cfg_c;
      end
   end

   // ----------------------------------------
   // Port drivers
   // ----------------------------------------
   assign PIN_PULL_EN_O = pull_en;
   assign STATUS_CHANGE_PIN_O = pin_out;
   assign STATUS_CHANGE_PIN_OE_N_O = pin_oe_n;
   assign PIN_CFG_A_O = cfg_a;
   assign PIN_CFG_B_O = cfg_b;
   assign PIN_CFG_C_O = cfg_c;

endmodule

`default_nettype wire

/* File: src/mpc_sync.sv */
// Two-flop synchroniser for levels coming from pins.
// Assumes the input changes slowly against CLOCK_I.
`timescale 1ns/1ns
`default_nettype none

module mpc_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // First stage feeds the second stage only
   always_comb begin
      next_meta = d_i;
      next_q = meta;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= next_meta;
         q_o <= next_q;
      end
   end
endmodule

`default_nettype wire

/* File: test/mpc_card_model.sv */
// Card-side partner: wake flag source, mode strap and status-change wire.
// Assumes requests from the bench change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module mpc_card_model (
   input wire logic clk_i,
   input wire logic wake_req_i,
   input wire logic mode_req_i,
   input wire logic oe_n_i,
   input wire logic drv_i,
   output logic wake_o,
   output logic mode_o,
   output wire logic pin_o
);
   always_ff @(posedge clk_i) begin
      wake_o <= wake_req_i;
      mode_o <= mode_req_i;
   end
   // Released wire has a host pull-up, so it never keeps the last driven level
   assign pin_o = oe_n_i ? 1'b1 : drv_i;
endmodule
`default_nettype wire

/* File: test/mpc_misc_pin_ctrl_props.sv */
// Concurrent checks on the misc pin control top-level ports.
// Assumes one clock, one AHB-Lite master, bound by name to the top module.
`timescale 1ns/1ns
`default_nettype none
module mpc_misc_pin_ctrl_props (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic CARD_WAKE_I,
   input wire logic PCCARD_MODE_I,
   input wire logic STATUS_CHANGE_PIN_I,
   input wire logic STATUS_CHANGE_PIN_O,
   input wire logic STATUS_CHANGE_PIN_OE_N_O,
   input wire logic PIN_PULL_EN_O,
   input wire logic [7:0] PIN_CFG_C_O
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic wq;
   logic [7:0] aq;
   logic mw;
   logic rd0;
   logic fn;
   logic drv_on;
   always_ff @(posedge CLOCK_I) begin
      wq <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I && RST_N_I;
      aq <= HADDR_I[7:0];
   end
   // A write to the control word is in its data phase
   assign mw = wq && aq == 8'h00;
   assign rd0 = HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I && HADDR_I[7:0] == 8'h00;
   assign fn = PIN_CFG_C_O[0];
   assign drv_on = !STATUS_CHANGE_PIN_OE_N_O;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_pull_on; mw && !HWDATA_I[2] |-> ##2 PIN_PULL_EN_O; endproperty
   a_pull_on: assert property (p_pull_on) else $error("pulls off after clear");
   property p_pull_off; mw && HWDATA_I[2] |-> ##2 !PIN_PULL_EN_O; endproperty
   a_pull_off: assert property (p_pull_off) else $error("pulls on after set");
   property p_set; mw && fn && CARD_WAKE_I && HWDATA_I[0] && drv_on |-> ##2 !STATUS_CHANGE_PIN_O;
   endproperty
   a_set: assert property (p_set) else $error("drive not set with wake");
   property p_clr; fn && !CARD_WAKE_I && drv_on |-> ##2 STATUS_CHANGE_PIN_O; endproperty
   a_clr: assert property (p_clr) else $error("drive not cleared by wake low");
   property p_inv; mw && !fn && drv_on |-> ##2 STATUS_CHANGE_PIN_O == !$past(HWDATA_I[0], 2);
   endproperty
   a_inv: assert property (p_inv) else $error("pin not inverse of written bit");
   property p_rd; STATUS_CHANGE_PIN_I [*4] ##0 rd0 |-> ##2 !HRDATA_O[0]; endproperty
   a_rd: assert property (p_rd) else $error("read bit not inverse of pin");
   property p_isa; !PCCARD_MODE_I [*5] |-> STATUS_CHANGE_PIN_OE_N_O; endproperty
   a_isa: assert property (p_isa) else $error("pin driven in other bus mode");
   property p_pcc; PCCARD_MODE_I [*5] |-> !STATUS_CHANGE_PIN_OE_N_O; endproperty
   a_pcc: assert property (p_pcc) else $error("pin not driven in card mode");
endmodule
bind mpc_misc_pin_ctrl mpc_misc_pin_ctrl_props i_mpc_misc_pin_ctrl_props (.*);
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the misc pin control block.
// Assumes the design answers writes at once and reads after one wait.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic wake_req = 1'b0;
   logic mode_req = 1'b1;
   logic wake, mode, pin, pin_o, oe_n, pull_en;
   logic [7:0] cfg [3];
   logic [31:0] q;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   mpc_misc_pin_ctrl i_mpc_misc_pin_ctrl (.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .CARD_WAKE_I(wake), .PCCARD_MODE_I(mode),
      .STATUS_CHANGE_PIN_I(pin), .STATUS_CHANGE_PIN_O(pin_o),
      .STATUS_CHANGE_PIN_OE_N_O(oe_n), .PIN_PULL_EN_O(pull_en), .PIN_CFG_A_O(cfg[0]),
      .PIN_CFG_B_O(cfg[1]), .PIN_CFG_C_O(cfg[2]));
   mpc_card_model i_mpc_card_model (.clk_i(clk), .wake_req_i(wake_req), .mode_req_i(mode_req),
      .oe_n_i(oe_n), .drv_i(pin_o), .wake_o(wake), .mode_o(mode), .pin_o(pin));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One single transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("rdata", q, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      idle(16);
      rst_n <= 1'b1;
      idle(6);
      chk("pull", {31'h0, pull_en}, 32'h1);
      chk("oe_n", {31'h0, oe_n}, 32'h0);
      rd(8'h00, 32'h0);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 8'h04 + 8'(4 * i), 32'h30 + i);
         rd(8'h04 + 8'(4 * i), 32'h30 + i);
         chk("cfg", {24'h0, cfg[i]}, 32'h30 + i);
      end
      bus(1'b1, 8'h00, 32'h4);
      idle(2);
      chk("pull", {31'h0, pull_en}, 32'h0);
      bus(1'b1, 8'h00, 32'h1);
      idle(5);
      chk("pin", {31'h0, pin_o}, 32'h0);
      rd(8'h00, 32'h1);
      bus(1'b1, 8'h00, 32'h2);
      idle(5);
      chk("pin", {31'h0, pin_o}, 32'h1);
      bus(1'b1, 8'h04, 32'hff);
      rd(8'h04, 32'h30);
      chk("cfg", {24'h0, cfg[0]}, 32'h30);
      rd(8'h00, 32'h2);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h0c, 32'h33);
      idle(2);
      chk("cfg", {24'h0, cfg[2]}, 32'h33);
      // Wake flag low: a write of 1 must not take
      bus(1'b1, 8'h00, 32'h1);
      idle(2);
      chk("pin", {31'h0, pin_o}, 32'h1);
      wake_req <= 1'b1;
      idle(2);
      bus(1'b1, 8'h00, 32'h1);
      idle(2);
      chk("pin", {31'h0, pin_o}, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      idle(2);
      chk("pin", {31'h0, pin_o}, 32'h0);
      wake_req <= 1'b0;
      idle(4);
      chk("pin", {31'h0, pin_o}, 32'h1);
      // Other bus mode: drive frozen and pin released
      mode_req <= 1'b0;
      wake_req <= 1'b1;
      idle(8);
      chk("oe_n", {31'h0, oe_n}, 32'h1);
      bus(1'b1, 8'h00, 32'h1);
      mode_req <= 1'b1;
      idle(8);
      chk("pin", {31'h0, pin_o}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, 8'h10 + 8'(4 * i), 32'h0);
         rd(8'h10 + 8'(4 * i), 32'h0);
      end
      rd(8'h3c, 32'h0);
      rd(8'h28, 32'h7);
      // Mid-run reset brings every output back to its reset level
      rst_n <= 1'b0;
      idle(3);
      chk("rst_pins", {28'h0, hready, pull_en, pin_o, oe_n}, 32'hf);
      chk("rst_cfg", {8'h0, cfg[0], cfg[1], cfg[2]}, 32'h0);
      rst_n <= 1'b1;
      idle(6);
      chk("oe_n", {31'h0, oe_n}, 32'h0);
      rd(8'h00, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
